// [event_window_counter.sv]
/*
 * 16-bit up-counter with timer, event counter and window modes,
 * byte-wise compare loading and a one-cycle match pulse.
 * Assumes internal_tick is a one-cycle pulse on mclk from the prescaler
 * for the selected internal source, and that the power state inputs
 * are synchronous to mclk.
 */
`timescale 1ns/100ps
`include "event_window_counter_consts.svh"

// Notes on behaviour
// - Three modes: timer, event, window.
// - Timer mode times oscillator warm-up.
// - Timer counts ticks; match pulses, clears.
// - Counting resumes from zero automatically.
// - Warm-up match uses upper five bits.
// - Event mode counts pin rising edges.
// - Event match pulses, clears, keeps counting.
// - Event match checked on falling edge.
// - Window counts ticks while pin high.
// - Window match pulses and clears counter.
// - No window counting in low-speed/sleep.
// - Stop entry clears run bit.
// - Compare loads lower byte then upper.
// - Old compare holds until upper written.
module event_window_counter (
	input  wire logic              mclk,                   // System clock, 125 MHz
	input  wire logic              rst,                    // Async reset, active high
	input  wire logic              counter_input_pin,      // External event or window pin
	input  wire logic              internal_tick,          // Selected internal clock pulse
	input  wire logic [1:0]        operating_mode_select,  // Mode code
	input  wire logic [2:0]        source_clock_select,    // Source clock code
	input  wire logic              run_write,              // Strobe: load run bit
	input  wire logic              run_value,              // Run bit value to load
	input  wire logic              stop_entry,             // Pulse: entering stop state
	input  wire logic              low_speed_state,        // Low-speed run state
	input  wire logic              sleep_state,            // Sleep state
	input  wire logic              lower_write,            // Strobe: lower compare byte
	input  wire logic [7:0]        compare_value_lower_byte, // Lower byte data
	input  wire logic              upper_write,            // Strobe: upper compare byte
	input  wire logic [7:0]        compare_value_upper_byte, // Upper byte data
	output logic                   run_control_bit,        // Run bit as held
	output logic [15:0]            count_value,            // Up-counter value
	output logic [15:0]            compare_value_reg,      // Active compare value
	output logic                   counter_match_irq       // One-cycle match pulse
);

	event_window_counter_pkg::counter_state_t st_q;  // Registered state
	event_window_counter_pkg::counter_state_t st_d;  // Next state

	logic pin_level;     // Synchronised pin level
	logic pin_rise;      // Synchronised rising edge
	logic pin_fall;      // Synchronised falling edge
	logic warm_case;     // High-frequency source during low-speed
	logic full_match;    // All compare bits equal
	logic warm_match;    // Upper five bits equal
	logic match;         // Match as used by the active case
	logic timer_mode;    // Timer mode selected
	logic event_mode;    // Event mode selected
	logic window_mode;   // Window mode selected
	logic window_ok;     // Window allowed in this power state
	logic count_step;    // Counter advances this cycle
	logic match_now;     // Match acted on this cycle

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and edge detection
	pin_edge_sync u_pin_sync (
		.mclk   (mclk),
		.rst    (rst),
		.pin_in (counter_input_pin),
		.level  (pin_level),
		.rise   (pin_rise),
		.fall   (pin_fall)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode decode and compare
	assign timer_mode  = (operating_mode_select == `MODE_TIMER);
	assign event_mode  = (operating_mode_select == `MODE_EVENT);
	assign window_mode = (operating_mode_select == `MODE_WINDOW);
	// Window gating is unreliable on the slow clock, so it is held off
	assign window_ok   = ~low_speed_state & ~sleep_state;

	assign warm_case  = timer_mode & low_speed_state
	                  & (source_clock_select == `SRC_HIGH_FREQ);
	assign full_match = (st_q.cnt == st_q.cmp);
	assign warm_match = (st_q.cnt[`CNT_W-1:`WARM_LSB] == st_q.cmp[`CNT_W-1:`WARM_LSB]);
	assign match      = warm_case ? warm_match : full_match;

	////////////////////////////////////////////////////////////////////////////
	// Count and match qualifiers per mode
	always_comb begin
		count_step = 1'b0;
		match_now  = 1'b0;
		if (st_q.run) begin
			if (timer_mode) begin
				// External source code counts pin edges in timer mode
				if (source_clock_select == `SRC_EXTERNAL) begin
					count_step = pin_rise;
				end else begin
					count_step = internal_tick;
				end
				match_now = match;
			end else if (event_mode) begin
				count_step = pin_rise;
				// Match waits for the falling edge after the count
				match_now  = pin_fall & full_match;
			end else if (window_mode && window_ok) begin
				count_step = internal_tick & pin_level;
				match_now  = full_match;
			end else begin
				// Reserved mode, or window in low-speed or sleep: hold
				count_step = 1'b0;
				match_now  = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_d     = st_q;
		st_d.irq = match_now;

		// Run bit: stop entry wins over a software write
		if (stop_entry) begin
			st_d.run = 1'b0;
		end else if (run_write) begin
			st_d.run = run_value;
		end

		// Counter: stopped clears, match clears, else step
		if (!st_q.run) begin
			st_d.cnt = `CNT_RST;
		end else if (match_now) begin
			st_d.cnt = `CNT_RST;
		end else if (count_step) begin
			st_d.cnt = st_q.cnt + `CNT_W'(1);
		end

		// Compare loading: lower then upper
		if (lower_write) begin
			st_d.low_hold = compare_value_lower_byte;
			st_d.low_pend = 1'b1;
		end
		if (upper_write) begin
			if (st_q.low_pend) begin
				st_d.cmp      = {compare_value_upper_byte, st_q.low_hold};
				st_d.low_pend = lower_write;
			end else if (warm_case) begin
				// Warm-up loads only the upper byte; lower bits are ignored
				st_d.cmp = {compare_value_upper_byte, st_q.cmp[`BYTE_W-1:0]};
			end
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q.cnt      <= `CNT_RST;
			st_q.cmp      <= `CMP_RST;
			st_q.low_hold <= `BYTE_RST;
			st_q.low_pend <= 1'b0;
			st_q.run      <= 1'b0;
			st_q.irq      <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign run_control_bit   = st_q.run;
	assign count_value       = st_q.cnt;
	assign compare_value_reg = st_q.cmp;
	assign counter_match_irq = st_q.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Timer match followed by clear and pulse
	sequence s_timer_match;
		st_q.run && timer_mode && !warm_case && full_match && !stop_entry && !(run_write && !run_value);
	endsequence

	sequence s_clear_and_pulse;
		(st_q.cnt == 16'h0000) && counter_match_irq;
	endsequence

	a_irq_single_pulse: assert property (
		counter_match_irq |=> !counter_match_irq || $past(match_now))
		else $error("match pulse held without new match");

	a_timer_match_clear: assert property (
		s_timer_match |=> s_clear_and_pulse)
		else $error("timer match did not clear and pulse");

	a_timer_resume: assert property (
		s_timer_match ##1 (st_q.run && timer_mode && internal_tick && !full_match
			&& source_clock_select != `SRC_EXTERNAL && !stop_entry)
		|=> st_q.cnt == 16'h0001)
		else $error("timer did not resume from zero");

	a_stop_clears_run: assert property (
		stop_entry |=> !run_control_bit ##1 (count_value == 16'h0000))
		else $error("stop entry left counter running");

	a_event_rise_count: assert property (
		st_q.run && event_mode && pin_rise && !stop_entry && !run_write
		|=> count_value == $past(count_value) + 16'h0001)
		else $error("event edge not counted");

	a_event_fall_match: assert property (
		st_q.run && event_mode && !pin_fall |=> !counter_match_irq)
		else $error("event match pulse without falling edge");

	a_window_gate_low: assert property (
		st_q.run && window_mode && !pin_level && !full_match && !stop_entry && !run_write
		|=> $stable(count_value))
		else $error("window counted with pin low");

	a_window_lowspeed: assert property (
		window_mode && !window_ok |=> !counter_match_irq)
		else $error("window active in low-speed or sleep");

	a_compare_hold: assert property (
		!upper_write |=> $stable(compare_value_reg))
		else $error("compare changed without upper write");

	a_warm_mask: assert property (
		st_q.run && warm_case && warm_match && !stop_entry && !(run_write && !run_value)
		|=> counter_match_irq && count_value == 16'h0000)
		else $error("warm-up upper bit match missed");

endmodule : event_window_counter

// [event_window_counter_consts.svh]
/*
 * Constants for the 16-bit timer / event / window counter:
 * mode codes, source clock codes, field positions and reset values.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef EVENT_WINDOW_COUNTER_CONSTS_SVH
`define EVENT_WINDOW_COUNTER_CONSTS_SVH

// Counter and compare width
`define CNT_W            16
// Byte width of one compare half
`define BYTE_W           8

// Operating mode codes
`define MODE_TIMER       2'h0
`define MODE_EVENT       2'h1
`define MODE_WINDOW      2'h2

// Source clock codes
`define SRC_HIGH_FREQ    3'h4
`define SRC_EXTERNAL     3'h7

// Lowest compare bit kept during warm-up matching
`define WARM_LSB         11

// Reset values
`define CNT_RST          16'h0000
`define CMP_RST          16'hFFFF
`define BYTE_RST         8'h00

`endif

// [event_window_counter_pkg.sv]
/*
 * Types shared by the counter design files.
 * Assumes event_window_counter_consts.svh is reachable on the include path.
 */
`include "event_window_counter_consts.svh"

package event_window_counter_pkg;

	// Whole state of the counter core
	typedef struct packed {
		logic [`CNT_W-1:0]  cnt;       // Up-counter
		logic [`CNT_W-1:0]  cmp;       // Active compare value
		logic [`BYTE_W-1:0] low_hold;  // Lower byte waiting for upper
		logic               low_pend;  // Lower byte written, upper not yet
		logic               run;       // Run control bit
		logic               irq;       // Match pulse
	} counter_state_t;

	// State of the pin synchroniser
	typedef struct packed {
		logic s1;    // First sync stage
		logic s2;    // Second sync stage
		logic s3;    // Previous synced level for edge detection
		logic rise;  // Rising edge pulse
		logic fall;  // Falling edge pulse
	} pin_sync_t;

endpackage : event_window_counter_pkg

// [pin_edge_sync.sv]
/*
 * Two-stage synchroniser with rising and falling edge pulses.
 * Assumes the input is asynchronous to mclk and each level lasts
 * at least two mclk periods.
 */
`timescale 1ns/100ps

module pin_edge_sync (
	input  wire logic mclk,      // System clock
	input  wire logic rst,       // Async reset, active high
	input  wire logic pin_in,    // Asynchronous pin
	output logic      level,     // Synchronised level
	output logic      rise,      // One-cycle rising edge pulse
	output logic      fall       // One-cycle falling edge pulse
);

	event_window_counter_pkg::pin_sync_t st_q;  // Registered state
	event_window_counter_pkg::pin_sync_t st_d;  // Next state

	////////////////////////////////////////////////////////////////////////////
	// Next state; edges look only at stages two and three
	always_comb begin
		st_d      = st_q;
		st_d.s1   = pin_in;
		st_d.s2   = st_q.s1;
		st_d.s3   = st_q.s2;
		st_d.rise = st_q.s2 & ~st_q.s3;
		st_d.fall = ~st_q.s2 & st_q.s3;
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.s3;
	assign rise  = st_q.rise;
	assign fall  = st_q.fall;

endmodule : pin_edge_sync

// [pulse_source.sv]
/*
 * Far-side model: external pulse source driving the counter pin.
 * Assumes start is a one-cycle strobe and width stays put during a burst.
 */
`timescale 1ns/100ps

module pulse_source (
	input  wire logic       mclk,    // System clock
	input  wire logic       rst,     // Async reset, active high
	input  wire logic       start,   // Strobe: begin a burst
	input  wire logic [7:0] pulses,  // Pulses in the burst
	input  wire logic [7:0] width,   // Cycles per phase
	output logic            pin,     // Pin drive, idles low
	output logic            busy     // Burst in progress
);
	logic [7:0] left;  // Phases still to run
	logic [7:0] ph;    // Cycles left in this phase

	////////////////////////////////////////////////////////////////
	// Burst generator; width floored at two so no phase is too short
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin  <= 1'b0;
			busy <= 1'b0;
			left <= 8'h00;
			ph   <= 8'h00;
		end else if (!busy) begin
			if (start && pulses != 8'h00) begin
				busy <= 1'b1;
				pin  <= 1'b1;
				left <= {pulses[6:0], 1'b0};
				ph   <= (width < 8'h02) ? 8'h02 : width;
			end
		end else if (ph > 8'h01) begin
			ph <= ph - 8'h01;
		end else begin
			// Last low phase ends the burst, pin stays low
			if (left == 8'h01) busy <= 1'b0;
			else pin <= ~pin;
			left <= left - 8'h01;
			ph   <= (width < 8'h02) ? 8'h02 : width;
		end
	end
endmodule : pulse_source

// [event_window_counter_tb.sv]
/*
 * Self-checking bench for the timer / event / window counter.
 * Assumes the design and pulse_source are compiled before it.
 */
`timescale 1ns/100ps

module event_window_counter_tb;
	logic        mclk, rst, pin, tick, run_write, run_value, stop_entry;  // Clock, reset, strobes
	logic        low_speed, sleep, lower_write, upper_write, start, busy;  // States, strobes
	logic [1:0]  mode;       // Mode code
	logic [2:0]  src;        // Source code
	logic [7:0]  lo, up, np, pw;  // Byte data, burst shape
	logic        run_bit, irq;    // Design outputs
	logic [15:0] cnt, cmp;        // Design outputs
	int          num_errors, checks_done, irqs;  // Tallies

	event_window_counter dut (.mclk(mclk), .rst(rst), .counter_input_pin(pin), .internal_tick(tick),
		.operating_mode_select(mode), .source_clock_select(src), .run_write(run_write),
		.run_value(run_value), .stop_entry(stop_entry), .low_speed_state(low_speed),
		.sleep_state(sleep), .lower_write(lower_write), .compare_value_lower_byte(lo),
		.upper_write(upper_write), .compare_value_upper_byte(up), .run_control_bit(run_bit),
		.count_value(cnt), .compare_value_reg(cmp), .counter_match_irq(irq));
	pulse_source src_model (.mclk(mclk), .rst(rst), .start(start), .pulses(np), .width(pw),
		.pin(pin), .busy(busy));

	////////////////////////////////////////////////////////////////
	// Clock and match pulse tally; a stretched pulse counts twice
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) if (irq === 1'b1) irqs++;

	////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	// One tick every other cycle keeps each strobe a single assignment
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge mclk) tick = 1'b1;
			@(negedge mclk) tick = 1'b0;
		end
	endtask : ticks
	task automatic set_run(input logic v);
		@(negedge mclk) begin run_write = 1'b1; run_value = v; end
		@(negedge mclk) run_write = 1'b0;
	endtask : set_run
	task automatic load_cmp(input logic [15:0] v);
		@(negedge mclk) begin lower_write = 1'b1; lo = v[7:0]; end
		@(negedge mclk) begin lower_write = 1'b0; upper_write = 1'b1; up = v[15:8]; end
		@(negedge mclk) upper_write = 1'b0;
	endtask : load_cmp
	task automatic setup(input logic [1:0] m, input logic [2:0] s, input logic [15:0] v);
		set_run(1'b0);
		mode = m;
		src  = s;
		load_cmp(v);
		set_run(1'b1);
		irqs = 0;
	endtask : setup
	task automatic burst(input logic [7:0] n, input logic [7:0] w);
		@(negedge mclk) begin start = 1'b1; np = n; pw = w; end
		@(negedge mclk) start = 1'b0;
	endtask : burst
	// Bounded wait for the source, then the synchroniser latency
	task automatic burst_done;
		for (int i = 0; i < 600 && busy; i++) @(negedge mclk);
		cyc(6);
	endtask : burst_done

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		check("run", 16'(run_bit), 16'h0000);
		check("count", cnt, 16'h0000);
		check("compare", cmp, 16'hFFFF);
		check("irq", 16'(irq), 16'h0000);
	endtask : t_reset
	task automatic t_compare;
		@(negedge mclk) begin lower_write = 1'b1; lo = 8'h34; end
		@(negedge mclk) lower_write = 1'b0;
		check("lower only", cmp, 16'hFFFF);
		load_cmp(16'hABCD);
		check("pair", cmp, 16'hABCD);
		@(negedge mclk) begin upper_write = 1'b1; up = 8'h55; end
		@(negedge mclk) upper_write = 1'b0;
		check("upper only", cmp, 16'hABCD);
	endtask : t_compare
	task automatic t_timer;
		setup(2'h0, 3'h0, 16'h0005);
		ticks(5);
		// Tick right after the match, so the restart from zero is exercised
		@(negedge mclk) tick = 1'b1;
		check("timer pulse", 16'(irq), 16'h0001);
		check("timer clear", cnt, 16'h0000);
		@(negedge mclk) tick = 1'b0;
		ticks(1);
		check("timer irq", 16'(irqs), 16'h0001);
		check("timer resume", cnt, 16'h0002);
	endtask : t_timer
	task automatic t_warm;
		set_run(1'b0);
		src = 3'h4;
		low_speed = 1'b1;
		@(negedge mclk) begin upper_write = 1'b1; up = 8'h10; end
		@(negedge mclk) upper_write = 1'b0;
		check("warm upper", cmp, 16'h1005);
		set_run(1'b1);
		irqs = 0;
		ticks(4095);
		check("warm early", 16'(irqs), 16'h0000);
		ticks(1);
		cyc(2);
		check("warm match", 16'(irqs), 16'h0001);
		low_speed = 1'b0;
	endtask : t_warm
	task automatic t_event;
		setup(2'h1, 3'h7, 16'h0003);
		burst(8'h02, 8'h03);
		burst_done();
		check("event count", cnt, 16'h0002);
		burst(8'h01, 8'h14);
		cyc(12);
		check("match waits fall", 16'(irqs), 16'h0000);
		check("event at cmp", cnt, 16'h0003);
		burst_done();
		check("event irq", 16'(irqs), 16'h0001);
		check("event clear", cnt, 16'h0000);
	endtask : t_event
	task automatic t_window;
		setup(2'h2, 3'h0, 16'h0004);
		ticks(3);
		check("window closed", cnt, 16'h0000);
		burst(8'h01, 8'h3C);
		cyc(5);
		ticks(2);
		check("window open", cnt, 16'h0002);
		sleep = 1'b1;
		ticks(2);
		check("window sleep", cnt, 16'h0002);
		sleep = 1'b0;
		ticks(2);
		cyc(2);
		check("window irq", 16'(irqs), 16'h0001);
		check("window clear", cnt, 16'h0000);
		burst_done();
		// Software halts window counting at the end of the scenario
		set_run(1'b0);
	endtask : t_window
	// Counter is left non-zero so the clear after stop can be seen
	task automatic t_stop;
		set_run(1'b1);
		burst(8'h01, 8'h3C);
		cyc(5);
		ticks(2);
		check("stop before", cnt, 16'h0002);
		@(negedge mclk) begin stop_entry = 1'b1; run_write = 1'b1; run_value = 1'b1; end
		@(negedge mclk) begin stop_entry = 1'b0; run_write = 1'b0; end
		check("stop run", 16'(run_bit), 16'h0000);
		cyc(1);
		check("stop count", cnt, 16'h0000);
		burst_done();
	endtask : t_stop
	// Timer mode on the pin source, then the reserved mode code
	task automatic t_ext_src;
		setup(2'h0, 3'h7, 16'h0003);
		burst(8'h02, 8'h03);
		burst_done();
		check("ext timer count", cnt, 16'h0002);
		burst(8'h01, 8'h03);
		burst_done();
		check("ext timer irq", 16'(irqs), 16'h0001);
		check("ext timer clear", cnt, 16'h0000);
		mode = 2'h3;
		burst(8'h01, 8'h03);
		burst_done();
		check("reserved hold", cnt, 16'h0000);
	endtask : t_ext_src

	////////////////////////////////////////////////////////////////
	// Verdict and run end
	task automatic final_report;
		if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	// Watchdog: the sequence needs about 9000 cycles
	initial begin
		repeat (30000) @(posedge mclk);
		num_errors++;
		final_report();
	end

	// Main sequence
	initial begin
		{rst, tick, run_write, run_value, stop_entry, low_speed, sleep} = 7'h01 << 6;
		{lower_write, upper_write, start} = 3'h0;
		{lo, up, np, pw, mode, src} = 37'h0;
		num_errors = 0;
		checks_done = 0;
		irqs = 0;
		repeat (4) @(posedge mclk);
		@(negedge mclk) rst = 1'b0;
		t_reset();
		t_compare();
		t_timer();
		t_warm();
		t_event();
		t_window();
		t_stop();
		t_ext_src();
		final_report();
	end
endmodule : event_window_counter_tb
